// [shared/lamp_pkg.sv]
// Purpose: Constants and types for the backlight lamp driver
// Assumes: 32-bit register words, register access through a plain select port
// Notes: Register indices are local; offsets are not fixed by the device map
package lamp_pkg;
   // Register selects
   localparam logic [0:0] REG_CONTROL = 1'h0;
   localparam logic [0:0] REG_DURATION = 1'h1;
   // Control register field positions
   localparam int MIXER_SEL_BIT = 28;
   localparam int ENABLE_BIT = 27;
   localparam int PROTECT_BIT = 26;
   localparam int SRC_SEL_BIT = 25;
   localparam int SOFT_SYNC_BIT = 24;
   localparam int PRESCALE_MSB = 7;
   // Duration register field positions
   localparam int FLASH_MSB = 31;
   localparam int FLASH_LSB = 16;
   localparam int PAUSE_MSB = 15;
   localparam int PAUSE_LSB = 8;
   localparam int ION_MSB = 7;
   // Reset values
   localparam logic [31:0] CONTROL_RESET = 32'h0000_0000;
   localparam logic [31:0] DURATION_RESET = 32'h0000_0000;
   // Timing: start-up length, last base period index of a macro cycle
   localparam logic [3:0] STARTUP_BASE_PERIODS = 4'h8;
   localparam logic [1:0] MACRO_LAST_BASE = 2'h3;

   // Phase sequence of one lamp cycle
   typedef enum logic [2:0] {
      PH_IDLE = 3'b000,
      PH_STARTUP = 3'b001,
      PH_ION = 3'b010,
      PH_PAUSE = 3'b011,
      PH_FLASH = 3'b100
   } phase_t;

   // Phase lengths in use
   typedef struct packed {
      logic [15:0] flash_length;
      logic [7:0] pause_length;
      logic [7:0] ionisation_length;
   } durations_t;

   // Lamp output pins
   typedef struct packed {
      logic gate_drive_a;
      logic gate_drive_b;
      logic ignition_output;
      logic lamp_off_output;
   } lamp_pins_t;
endpackage : lamp_pkg

// [design/backlight_lamp_driver.sv]
// Purpose: Frame-synchronised backlight lamp phase sequencer and gate driver
// Assumes: Single 20 MHz clock, synchronous inputs, one-cycle register strobes
// Notes: Gate pulses alternate per half macro cycle with one dead base period
`timescale 1ns/100ps

// What this block does
// - Disabled: gates low, ignition low, off high
// - Protect set: stored durations change, active frozen
// - Protect clear: duration writes act at once
// - Source bit picks frame sync or software
// - Setting soft trigger bit gives sync pulse
// - Mixer select overrides source selection
// - Without mixer support bit 28 reads zero
// - Prescaler in bits 7:0, 23:8 reserved
// - Flash, pause, ionisation fields reset zero
// - Phase lengths counted in four-period macros
// - Base period is prescaler clocks; start-up eight
// - Phase sequence drives the documented output levels
// - Sync before flash end is ignored
// - Phase end cuts a high gate pulse
module backlight_lamp_driver #(
   parameter bit MIXER_SUPPORT = 1'b1
) (
   input wire logic sys_clk,
   input wire logic rst_b,
   input wire logic reg_write,
   input wire logic reg_read,
   input wire logic [0:0] reg_select,
   input wire logic [31:0] reg_wdata,
   output logic [31:0] reg_rdata,
   input wire logic frame_sync,
   input wire logic mixer_sync,
   output lamp_pkg::lamp_pins_t lamp_pins
);

   // ----------------------------------------------------------------
   // Register file
   // ----------------------------------------------------------------
   logic [31:0] control_r, control_nxt;
   lamp_pkg::durations_t stored_r, stored_nxt;
   lamp_pkg::durations_t active_r, active_nxt;
   logic [31:0] rdata_r, rdata_nxt;
   logic [31:0] ctrl_wmask;
   logic protect;

   // Writable control bits; reserved bits and absent mixer bit stay zero
   always_comb begin
      ctrl_wmask = 32'h0f00_00ff;
      ctrl_wmask[lamp_pkg::MIXER_SEL_BIT] = MIXER_SUPPORT;
   end

   assign protect = control_r[lamp_pkg::PROTECT_BIT];

   // Register writes, shadowing and read data
   always_comb begin
      control_nxt = control_r;
      stored_nxt = stored_r;
      active_nxt = active_r;
      rdata_nxt = rdata_r;
      if (reg_write && reg_select == lamp_pkg::REG_CONTROL) begin
         control_nxt = reg_wdata & ctrl_wmask;
      end
      if (reg_write && reg_select == lamp_pkg::REG_DURATION) begin
         stored_nxt = reg_wdata;
      end
      if (!protect) begin
         active_nxt = stored_nxt;
      end
      if (reg_read) begin
         rdata_nxt = (reg_select == lamp_pkg::REG_CONTROL) ? control_r : stored_r;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_b) begin
         control_r <= lamp_pkg::CONTROL_RESET;
         stored_r <= lamp_pkg::DURATION_RESET;
         active_r <= lamp_pkg::DURATION_RESET;
         rdata_r <= 32'h0000_0000;
      end else begin
         control_r <= control_nxt;
         stored_r <= stored_nxt;
         active_r <= active_nxt;
         rdata_r <= rdata_nxt;
      end
   end

   assign reg_rdata = rdata_r;

   // ----------------------------------------------------------------
   // Sync selection and edge detection
   // ----------------------------------------------------------------
   logic sync_level, sync_prev_r, sync_prev_nxt, sync_rise;
   logic enable;

   assign enable = control_r[lamp_pkg::ENABLE_BIT];

   // Mixer select wins over source select
   always_comb begin
      if (control_r[lamp_pkg::MIXER_SEL_BIT]) begin
         sync_level = mixer_sync;
      end else if (control_r[lamp_pkg::SRC_SEL_BIT]) begin
         sync_level = control_r[lamp_pkg::SOFT_SYNC_BIT];
      end else begin
         sync_level = frame_sync;
      end
      sync_prev_nxt = sync_level;
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_b) begin
         sync_prev_r <= 1'b0;
      end else begin
         sync_prev_r <= sync_prev_nxt;
      end
   end

   assign sync_rise = sync_level && !sync_prev_r;

   // ----------------------------------------------------------------
   // Base period divider
   // ----------------------------------------------------------------
   logic [7:0] div_r, div_nxt;
   logic base_tick;
   logic [7:0] prescale;

   assign prescale = control_r[lamp_pkg::PRESCALE_MSB:0];

   // One tick every prescaler clocks; zero behaves as one; held at zero while idle
   always_comb begin
      base_tick = (div_r + 8'h01 >= prescale);
      div_nxt = (base_tick || phase_r == lamp_pkg::PH_IDLE) ? 8'h00 : div_r + 8'h01;
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_b) begin
         div_r <= 8'h00;
      end else begin
         div_r <= div_nxt;
      end
   end

   // ----------------------------------------------------------------
   // Phase sequencer
   // ----------------------------------------------------------------
   lamp_pkg::phase_t phase_r, phase_nxt;
   logic [15:0] macro_r, macro_nxt;
   logic [3:0] base_r, base_nxt;
   logic [15:0] phase_len;

   function automatic logic [15:0] len_of(input lamp_pkg::phase_t ph, input lamp_pkg::durations_t d);
      case (ph)
         lamp_pkg::PH_ION: len_of = {8'h00, d.ionisation_length};
         lamp_pkg::PH_PAUSE: len_of = {8'h00, d.pause_length};
         lamp_pkg::PH_FLASH: len_of = d.flash_length;
         default: len_of = 16'h0000;
      endcase
   endfunction : len_of

   function automatic lamp_pkg::phase_t after(input lamp_pkg::phase_t ph);
      case (ph)
         lamp_pkg::PH_STARTUP: after = lamp_pkg::PH_ION;
         lamp_pkg::PH_ION: after = lamp_pkg::PH_PAUSE;
         lamp_pkg::PH_PAUSE: after = lamp_pkg::PH_FLASH;
         default: after = lamp_pkg::PH_IDLE;
      endcase
   endfunction : after

   assign phase_len = len_of(phase_r, active_r);

   // Phase stepping; a zero-length phase is skipped
   always_comb begin
      phase_nxt = phase_r;
      macro_nxt = macro_r;
      base_nxt = base_r;
      case (phase_r)
         lamp_pkg::PH_IDLE: begin
            if (sync_rise) begin
               phase_nxt = lamp_pkg::PH_STARTUP;
               base_nxt = 4'h0;
               macro_nxt = 16'h0000;
            end
         end
         lamp_pkg::PH_STARTUP: begin
            if (base_tick) begin
               base_nxt = base_r + 4'h1;
               if (base_r == lamp_pkg::STARTUP_BASE_PERIODS - 4'h1) begin
                  phase_nxt = after(phase_r);
                  base_nxt = 4'h0;
               end
            end
         end
         lamp_pkg::PH_ION, lamp_pkg::PH_PAUSE, lamp_pkg::PH_FLASH: begin
            // Sync arriving here is ignored
            if (macro_r >= phase_len) begin
               phase_nxt = after(phase_r);
               macro_nxt = 16'h0000;
               base_nxt = 4'h0;
            end else if (base_tick) begin
               base_nxt = {2'b00, base_r[1:0] + 2'h1};
               if (base_r[1:0] == lamp_pkg::MACRO_LAST_BASE) begin
                  macro_nxt = macro_r + 16'h0001;
               end
            end
         end
         default: phase_nxt = lamp_pkg::PH_IDLE;
      endcase
      if (!enable) begin
         phase_nxt = lamp_pkg::PH_IDLE;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_b) begin
         phase_r <= lamp_pkg::PH_IDLE;
         macro_r <= 16'h0000;
         base_r <= 4'h0;
      end else begin
         phase_r <= phase_nxt;
         macro_r <= macro_nxt;
         base_r <= base_nxt;
      end
   end

   // ----------------------------------------------------------------
   // Output decode
   // ----------------------------------------------------------------
   lamp_pkg::lamp_pins_t pins_r, pins_nxt;
   logic pulsed;

   // Gate A in base period 0, gate B in base period 2 of each ionisation and flash macro; pins follow the next phase
   always_comb begin
      pulsed = (phase_nxt == lamp_pkg::PH_ION || phase_nxt == lamp_pkg::PH_FLASH) &&
         (macro_nxt < len_of(phase_nxt, active_nxt));
      pins_nxt.gate_drive_a = pulsed && base_nxt[1:0] == 2'h0;
      pins_nxt.gate_drive_b = pulsed && base_nxt[1:0] == 2'h2;
      pins_nxt.ignition_output =
         (phase_nxt == lamp_pkg::PH_STARTUP || phase_nxt == lamp_pkg::PH_ION);
      pins_nxt.lamp_off_output = (phase_nxt == lamp_pkg::PH_IDLE);
      if (!enable) begin
         pins_nxt = 4'b0001;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_b) begin
         pins_r <= 4'b0001;
      end else begin
         pins_r <= pins_nxt;
      end
   end

   assign lamp_pins = pins_r;

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   property p_disabled_outputs;
      @(posedge sys_clk) disable iff (!rst_b)
         !enable |=> (lamp_pins == 4'b0001);
   endproperty
   a_disabled_outputs: assert property (p_disabled_outputs) else $error("outputs active while disabled");

   property p_protect_freeze;
      @(posedge sys_clk) disable iff (!rst_b)
         protect && $past(protect) |-> $stable(active_r);
   endproperty
   a_protect_freeze: assert property (p_protect_freeze) else $error("active durations moved under protect");

   property p_direct_write;
      @(posedge sys_clk) disable iff (!rst_b)
         !protect && reg_write && reg_select == lamp_pkg::REG_DURATION |=> active_r == $past(reg_wdata);
   endproperty
   a_direct_write: assert property (p_direct_write) else $error("duration write not applied");

   property p_no_overlap;
      @(posedge sys_clk) disable iff (!rst_b)
         !(lamp_pins.gate_drive_a && lamp_pins.gate_drive_b);
   endproperty
   a_no_overlap: assert property (p_no_overlap) else $error("gates overlap");

   property p_mixer_zero;
      @(posedge sys_clk) disable iff (!rst_b)
         !MIXER_SUPPORT |-> !control_r[lamp_pkg::MIXER_SEL_BIT];
   endproperty
   a_mixer_zero: assert property (p_mixer_zero) else $error("mixer bit set without support");

   property p_reserved_zero;
      @(posedge sys_clk) disable iff (!rst_b)
         control_r[23:8] == 16'h0000;
   endproperty
   a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bits set");

   property p_sync_ignored;
      @(posedge sys_clk) disable iff (!rst_b)
         phase_r == lamp_pkg::PH_FLASH && macro_r < phase_len && enable |=> phase_r == lamp_pkg::PH_FLASH;
   endproperty
   a_sync_ignored: assert property (p_sync_ignored) else $error("flash phase left early");

   property p_start_on_sync;
      @(posedge sys_clk) disable iff (!rst_b)
         phase_r == lamp_pkg::PH_IDLE && sync_rise && enable |=> phase_r == lamp_pkg::PH_STARTUP ##1 lamp_pins.ignition_output;
   endproperty
   a_start_on_sync: assert property (p_start_on_sync) else $error("sync did not start cycle");

   property p_pause_low;
      @(posedge sys_clk) disable iff (!rst_b)
         phase_r == lamp_pkg::PH_PAUSE && $past(phase_r) == lamp_pkg::PH_PAUSE |-> lamp_pins == 4'b0000;
   endproperty
   a_pause_low: assert property (p_pause_low) else $error("pause outputs not low");

   c_full_cycle: cover property (@(posedge sys_clk) phase_r == lamp_pkg::PH_FLASH ##1 phase_r == lamp_pkg::PH_IDLE);
   c_gate_b: cover property (@(posedge sys_clk) lamp_pins.gate_drive_b);
   c_protect_write: cover property (@(posedge sys_clk) protect && reg_write && reg_select == lamp_pkg::REG_DURATION);

endmodule : backlight_lamp_driver

// [sim/lamp_converter_model.sv]
// Purpose: Converter and ignition side of the lamp pins, counting what it sees
// Assumes: Pins are registered on sys_clk; clear is driven by the bench
// Notes: Counts wrap at 16 bits
`timescale 1ns/100ps
module lamp_converter_model (
   input wire logic sys_clk,
   input wire logic clear,
   input wire lamp_pkg::lamp_pins_t lamp_pins,
   output logic [15:0] on_cnt,
   output logic [15:0] ign_cnt,
   output logic [15:0] rise_a,
   output logic [15:0] rise_b,
   output logic overlap
);
   logic last_a;
   logic last_b;
   // Lamp-on time, ignition time, gate pulses and shoot-through watch
   always @(posedge sys_clk) begin
      last_a <= lamp_pins.gate_drive_a;
      last_b <= lamp_pins.gate_drive_b;
      if (clear) begin
         on_cnt <= 16'h0;
         ign_cnt <= 16'h0;
         rise_a <= 16'h0;
         rise_b <= 16'h0;
         overlap <= 1'b0;
      end else begin
         on_cnt <= on_cnt + {15'h0, !lamp_pins.lamp_off_output};
         ign_cnt <= ign_cnt + {15'h0, lamp_pins.ignition_output};
         rise_a <= rise_a + {15'h0, lamp_pins.gate_drive_a && !last_a};
         rise_b <= rise_b + {15'h0, lamp_pins.gate_drive_b && !last_b};
         overlap <= overlap | (lamp_pins.gate_drive_a & lamp_pins.gate_drive_b);
      end
   end
endmodule : lamp_converter_model

// [sim/testbench.sv]
// Purpose: Register and lamp cycle tests of the backlight lamp driver
// Assumes: 20 MHz clock, prescaler 16 gives an 800 ns base period
// Notes: Phase counts allow a few clocks of exit latency
`timescale 1ns/100ps
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin bad_count++; \
   $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (a), (b)); end end
module testbench;
   logic sys_clk, rst_b, reg_write, reg_read, frame_sync, mixer_sync, clear;
   logic [0:0] reg_select;
   logic [31:0] reg_wdata, reg_rdata, rdata_nomix;
   lamp_pkg::lamp_pins_t lamp_pins;
   logic [15:0] on_cnt, ign_cnt, rise_a, rise_b;
   logic overlap;
   int bad_count, compares;
   backlight_lamp_driver dut (.sys_clk(sys_clk), .rst_b(rst_b), .reg_write(reg_write), .reg_read(reg_read),
      .reg_select(reg_select), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .frame_sync(frame_sync),
      .mixer_sync(mixer_sync), .lamp_pins(lamp_pins));
   backlight_lamp_driver #(.MIXER_SUPPORT(1'b0)) dut_nomix (.sys_clk(sys_clk), .rst_b(rst_b),
      .reg_write(reg_write), .reg_read(reg_read), .reg_select(reg_select), .reg_wdata(reg_wdata),
      .reg_rdata(rdata_nomix), .frame_sync(frame_sync), .mixer_sync(mixer_sync), .lamp_pins());
   lamp_converter_model conv (.sys_clk(sys_clk), .clear(clear), .lamp_pins(lamp_pins), .on_cnt(on_cnt),
      .ign_cnt(ign_cnt), .rise_a(rise_a), .rise_b(rise_b), .overlap(overlap));
   // Clock
   initial begin
      sys_clk = 1'b0;
      forever #25 sys_clk = ~sys_clk;
   end
   // Verdict and end of run
   task end_sim;
      $display("mismatches %0d of %0d compares", bad_count, compares);
      if (bad_count == 0 && compares > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : end_sim
   // Register write, one cycle strobe
   task wr(input logic [0:0] sel, input logic [31:0] data);
      @(posedge sys_clk);
      reg_write <= 1'b1;
      reg_select <= sel;
      reg_wdata <= data;
      @(posedge sys_clk);
      reg_write <= 1'b0;
   endtask : wr
   // Register read; data settles one cycle after the strobe
   task rd(input logic [0:0] sel, input logic [31:0] exp);
      @(posedge sys_clk);
      reg_read <= 1'b1;
      reg_select <= sel;
      @(posedge sys_clk);
      reg_read <= 1'b0;
      #1;
      `CHK(reg_rdata, exp)
   endtask : rd
   // Sync pulse: 0 frame, 1 mixer, 2 software trigger
   task pulse(input int kind, input logic [31:0] ctrl);
      if (kind == 2) begin
         wr(lamp_pkg::REG_CONTROL, ctrl | 32'h0100_0000);
         wr(lamp_pkg::REG_CONTROL, ctrl);
      end else begin
         @(posedge sys_clk);
         if (kind == 0) frame_sync <= 1'b1;
         else mixer_sync <= 1'b1;
         repeat (3) @(posedge sys_clk);
         frame_sync <= 1'b0;
         mixer_sync <= 1'b0;
      end
   endtask : pulse
   // One lamp cycle: a foreign sync first, then the chosen one, a repeat mid-cycle except for the software trigger
   task run(input int kind, input logic [31:0] ctrl, input int on_exp, input int ign_exp, input int rise_exp);
      @(posedge sys_clk);
      clear <= 1'b1;
      pulse((kind == 0) ? 1 : 0, ctrl);
      repeat (10) @(posedge sys_clk);
      `CHK(lamp_pins.lamp_off_output, 1'b1)
      clear <= 1'b0;
      pulse(kind, ctrl);
      repeat (200) @(posedge sys_clk);
      if (kind != 2) pulse(kind, ctrl);
      repeat (560) @(posedge sys_clk);
      #1;
      `CHK(on_cnt >= on_exp && on_cnt <= on_exp + 4, 1'b1)
      `CHK(ign_cnt >= ign_exp && ign_cnt <= ign_exp + 4, 1'b1)
      `CHK(rise_a, 16'(rise_exp))
      `CHK(rise_b, 16'(rise_exp))
      `CHK(overlap, 1'b0)
      `CHK(lamp_pins, 4'h1)
   endtask : run
   // Watchdog
   initial begin
      repeat (20000) @(posedge sys_clk);
      bad_count++;
      end_sim();
   end
   // Test sequence
   initial begin
      bad_count = 0;
      compares = 0;
      rst_b = 1'b0;
      reg_write = 1'b0;
      reg_read = 1'b0;
      reg_select = 1'h0;
      reg_wdata = 32'h0;
      frame_sync = 1'b0;
      mixer_sync = 1'b0;
      clear = 1'b1;
      repeat (4) @(posedge sys_clk);
      rst_b <= 1'b1;
      #1;
      `CHK(lamp_pins, 4'h1)
      rd(lamp_pkg::REG_CONTROL, 32'h0);
      rd(lamp_pkg::REG_DURATION, 32'h0);
      wr(lamp_pkg::REG_CONTROL, 32'h00ff_ff10);
      rd(lamp_pkg::REG_CONTROL, 32'h0000_0010);
      wr(lamp_pkg::REG_DURATION, 32'h0002_0101);
      rd(lamp_pkg::REG_DURATION, 32'h0002_0101);
      run(0, 32'h0000_0010, 0, 0, 0);
      wr(lamp_pkg::REG_CONTROL, 32'h0800_0010);
      run(0, 32'h0800_0010, 384, 192, 3);
      wr(lamp_pkg::REG_CONTROL, 32'h0a00_0010);
      run(2, 32'h0a00_0010, 384, 192, 3);
      wr(lamp_pkg::REG_CONTROL, 32'h1a00_0010);
      rd(lamp_pkg::REG_CONTROL, 32'h1a00_0010);
      `CHK(rdata_nomix, 32'h0a00_0010)
      run(1, 32'h1a00_0010, 384, 192, 3);
      wr(lamp_pkg::REG_CONTROL, 32'h0c00_0010);
      wr(lamp_pkg::REG_DURATION, 32'h0004_0101);
      rd(lamp_pkg::REG_DURATION, 32'h0004_0101);
      run(0, 32'h0c00_0010, 384, 192, 3);
      wr(lamp_pkg::REG_CONTROL, 32'h0800_0010);
      run(0, 32'h0800_0010, 512, 192, 5);
      wr(lamp_pkg::REG_DURATION, 32'h0001_0201);
      run(0, 32'h0800_0010, 384, 192, 2);
      end_sim();
   end
endmodule : testbench
